// ==== rtl/bps_bus_cycle.sv ====
/*
  One bus cycle engine: drives the bus pins for one 16-bit transfer.
  Assumes ack and data pins are asynchronous; on-chip data is same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module bps_bus_cycle (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [31:0] addr,
  input wire logic [1:0] size,
  input wire logic we,
  input wire logic [15:0] wdata,
  input wire logic ifetch,
  input wire logic onchip,
  input wire logic sync_mode,
  input wire logic [15:0] onchip_rdata,
  input wire logic ext_ack_n,
  input wire logic [15:0] ext_data_in,
  output logic busy,
  output logic done,
  output logic [15:0] rdata,
  output logic bus_as_n,
  output logic [31:0] bus_addr,
  output logic [1:0] bus_size,
  output logic bus_rd,
  output logic [15:0] bus_data_out,
  output logic bus_data_oe_n,
  output logic bus_ifetch
);
  import bps_pkg::*;

  logic ack_m, ack_s;
  logic [15:0] din_m, din_s;
  logic [3:0] cnt;
  logic quick, ext_fixed;
  logic finish;
  logic ack_rel;

  // Two-stage pin synchronisers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ack_m <= 1'b1;
      ack_s <= 1'b1;
      din_m <= 16'h0;
      din_s <= 16'h0;
    end else begin
      ack_m <= ext_ack_n;
      ack_s <= ack_m;
      din_m <= ext_data_in;
      din_s <= din_m;
    end
  end

  // End of cycle: fixed count or external acknowledge
  // Acknowledge counts only once seen released, so a late-negating pin cannot end the next cycle
  assign finish = quick ? (cnt == QUICK_LAST) :
                  ext_fixed ? (cnt == EXT_SYNC_LAST) : (ack_rel && !ack_s);

  // Cycle sequencing and pin drive
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= 4'h0;
      quick <= 1'b0;
      ext_fixed <= 1'b0;
      ack_rel <= 1'b0;
      rdata <= 16'h0;
      bus_as_n <= 1'b1;
      bus_addr <= 32'h0;
      bus_size <= SZ_WORD;
      bus_rd <= 1'b1;
      bus_data_out <= 16'h0;
      bus_data_oe_n <= 1'b1;
      bus_ifetch <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        cnt <= 4'h0;
        quick <= onchip;
        ext_fixed <= sync_mode;
        ack_rel <= 1'b0;
        bus_as_n <= onchip;
        bus_addr <= addr;
        bus_size <= size;
        bus_rd <= !we;
        bus_data_out <= wdata;
        bus_data_oe_n <= !we || onchip;
        bus_ifetch <= ifetch;
      end else if (busy) begin
        cnt <= cnt + 4'h1;
        ack_rel <= ack_rel | ack_s;
        if (finish) begin
          busy <= 1'b0;
          done <= 1'b1;
          rdata <= quick ? onchip_rdata : din_s;
          bus_as_n <= 1'b1;
          bus_data_oe_n <= 1'b1;
          bus_ifetch <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== rtl/bps_pkg.sv ====
/*
  Constants, enumerations and helpers shared by the bus prefetch scheduler.
  Assumes a single 25 MHz system clock and a 16-bit bus data path.
*/
package bps_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int BUS_MIN_NS = 80;
  localparam int BUS_MIN_CLKS = (BUS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COF_IDLE_NS = 80;
  localparam int COF_IDLE_CLKS = (COF_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] QUICK_LAST = 4'(BUS_MIN_CLKS - 2);
  localparam logic [3:0] EXT_SYNC_LAST = 4'(BUS_MIN_CLKS + SYNC_STAGES - 2);
  localparam logic [1:0] HOLD_LOAD = 2'(COF_IDLE_CLKS - 1);

  // ************************************************************
  // Pipeline and operand layout
  // ************************************************************
  localparam int PIPE_SLOTS = 3;
  localparam int PIPE_BUF = 1;
  localparam logic [2:0] ROOM_NORM = 3'(PIPE_SLOTS);
  localparam logic [2:0] ROOM_EARLY = 3'(PIPE_SLOTS + PIPE_BUF);
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [31:0] WORD_STEP = 32'h2;
  localparam logic [31:0] RESET_FETCH_ADDR = 32'h0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {BPS_K_PF, BPS_K_RD, BPS_K_WR} bps_kind_e;
  typedef enum logic [2:0] {BPS_S_NONE, BPS_S_LO, BPS_S_WR, BPS_S_RD, BPS_S_PF} bps_sel_e;

  // Lesser of two cycle counts
  function automatic logic [3:0] bps_min4(input logic [3:0] a, input logic [3:0] b);
    return (a < b) ? a : b;
  endfunction

endpackage

// ==== rtl/bps_scheduler.sv ====
/*
  Bus controller scheduler: prefetch controller, one-entry write buffer,
  operand/prefetch arbiter and instruction pipeline model.
  Assumes the microsequencer on the same clock and the bus cycle engine below.
*/
// Function
// - Flush and refill pipeline on flow change
// - Prefetch only without upcoming flow change, free slot
// - One pending write buffer frees the sequencer
// - Stall further writes while buffer occupied
// - Queued write runs during next instruction
// - Operand access beats prefetch for the bus
// - Byte and word operands use one cycle
// - Long operand: two cycles, high word first
// - Branch decode stops prefetching on current path
// - Overlap is lesser of tail and head
// - On-chip accesses finish in two clocks
// - Fixed priority gives repeatable bus ordering
// - Each instruction prefetches its own replacement
// - Replacement may start in indexed EA clock
// - Early replacement if bus free, else deferred
// - Two idle clocks after flow change, extra fetch
// - Two-clock bus matches sequencer cycle time
// - Prefetch when stage freed, after operand requests
// - Busy bus queues request, runs when free
`timescale 1ns/1ns
`default_nettype none
module bps_scheduler #(
  parameter logic [31:0] ONCHIP_MASK = 32'hffff0000,
  parameter logic [31:0] ONCHIP_BASE = 32'hffff0000
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic flow_change,
  input wire logic [31:0] flow_addr,
  input wire logic next_is_cof,
  input wire logic word_use,
  input wire logic repl_early,
  input wire logic opr_req,
  input wire logic opr_we,
  input wire logic [1:0] opr_size,
  input wire logic [31:0] opr_addr,
  input wire logic [31:0] opr_wdata,
  input wire logic [3:0] tail_cycles,
  input wire logic [3:0] head_cycles,
  input wire logic sync_mode,
  input wire logic [15:0] onchip_rdata,
  input wire logic ext_ack_n,
  input wire logic [15:0] ext_data_in,
  output logic wr_stall,
  output logic rd_busy,
  output logic rd_done,
  output logic [31:0] rd_data,
  output logic seq_hold,
  output logic [15:0] instr_word,
  output logic instr_valid,
  output logic [3:0] overlap_cycles,
  output logic bus_as_n,
  output logic [31:0] bus_addr,
  output logic [1:0] bus_size,
  output logic bus_rd,
  output logic [15:0] bus_data_out,
  output logic bus_data_oe_n,
  output logic bus_ifetch
);
  import bps_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic bus_start, bus_we_q, bus_if_q, bus_onchip_q;
  logic [31:0] bus_addr_q;
  logic [15:0] bus_wdata_q;
  logic [1:0] bus_size_q;
  bps_kind_e cur_kind;
  logic cur_long, cur_lo, cur_stale;
  logic wbuf_valid, wbuf_issued;
  logic [31:0] wbuf_addr, wbuf_data;
  logic [1:0] wbuf_size;
  logic rd_issued;
  logic [31:0] rd_addr;
  logic [1:0] rd_size;
  logic [15:0] rd_hi;
  logic [15:0] pipe_mem [PIPE_SLOTS+PIPE_BUF];
  logic [2:0] pipe_cnt, next_pipe_cnt, occ;
  logic pf_inflight;
  logic [31:0] pf_addr;
  logic [1:0] hold_cnt;
  logic bc_busy, bc_done;
  logic [15:0] bc_rdata;
  logic idle_now, lo_cont, pf_ok, wr_fin, rd_fin, push, pop;
  bps_sel_e sel;

  function automatic logic on_chip(input logic [31:0] a);
    return (a & ONCHIP_MASK) == ONCHIP_BASE;
  endfunction

  // ************************************************************
  // Arbitration
  // ************************************************************
  assign idle_now = !bus_start && !bc_busy;
  assign lo_cont = bc_done && cur_long && !cur_lo && (cur_kind != BPS_K_PF);
  assign occ = pipe_cnt + {2'h0, pf_inflight};
  assign wr_fin = bc_done && (cur_kind == BPS_K_WR) && (!cur_long || cur_lo);
  assign rd_fin = bc_done && (cur_kind == BPS_K_RD) && (!cur_long || cur_lo);

  // prefetch gate on upcoming flow and room
  // early room in indexed EA clock
  assign pf_ok = !flow_change && !next_is_cof &&
                 ((occ < ROOM_NORM) || (repl_early && (occ < ROOM_EARLY)));

  // Fixed priority grant when the bus is free
  always_comb begin
    sel = BPS_S_NONE;
    // queued request runs once bus frees
    if (idle_now) begin
      if (lo_cont) begin
        sel = BPS_S_LO;
      end else if (wbuf_valid && !wbuf_issued) begin
        sel = BPS_S_WR;
      end else if (rd_busy && !rd_issued) begin
        sel = BPS_S_RD;
      end else if (pf_ok) begin
        sel = BPS_S_PF;
      end
    end
  end

  // Cycle issue to the bus engine
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bus_start <= 1'b0;
      bus_addr_q <= 32'h0;
      bus_wdata_q <= 16'h0;
      bus_size_q <= SZ_WORD;
      bus_we_q <= 1'b0;
      bus_if_q <= 1'b0;
      bus_onchip_q <= 1'b0;
      cur_kind <= BPS_K_PF;
      cur_long <= 1'b0;
      cur_lo <= 1'b0;
    end else begin
      bus_start <= (sel != BPS_S_NONE);
      case (sel)
        BPS_S_LO: begin
          bus_addr_q <= bus_addr_q + WORD_STEP;
          bus_wdata_q <= wbuf_data[15:0];
          cur_lo <= 1'b1;
        end
        BPS_S_WR: begin
          bus_addr_q <= wbuf_addr;
          bus_wdata_q <= (wbuf_size == SZ_LONG) ? wbuf_data[31:16] : wbuf_data[15:0];
          bus_size_q <= (wbuf_size == SZ_LONG) ? SZ_WORD : wbuf_size;
          bus_we_q <= 1'b1;
          bus_if_q <= 1'b0;
          bus_onchip_q <= on_chip(wbuf_addr);
          cur_kind <= BPS_K_WR;
          cur_long <= (wbuf_size == SZ_LONG);
          cur_lo <= 1'b0;
        end
        // byte or word in one cycle
        BPS_S_RD: begin
          bus_addr_q <= rd_addr;
          bus_size_q <= (rd_size == SZ_LONG) ? SZ_WORD : rd_size;
          bus_we_q <= 1'b0;
          bus_if_q <= 1'b0;
          bus_onchip_q <= on_chip(rd_addr);
          cur_kind <= BPS_K_RD;
          cur_long <= (rd_size == SZ_LONG);
          cur_lo <= 1'b0;
        end
        BPS_S_PF: begin
          bus_addr_q <= pf_addr;
          bus_size_q <= SZ_WORD;
          bus_we_q <= 1'b0;
          bus_if_q <= 1'b1;
          bus_onchip_q <= on_chip(pf_addr);
          cur_kind <= BPS_K_PF;
          cur_long <= 1'b0;
          cur_lo <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // Operand queue
  // ************************************************************
  // One-entry write buffer
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wbuf_valid <= 1'b0;
      wbuf_issued <= 1'b0;
      wbuf_addr <= 32'h0;
      wbuf_data <= 32'h0;
      wbuf_size <= SZ_WORD;
    end else begin
      if (wr_fin) begin
        wbuf_valid <= 1'b0;
        wbuf_issued <= 1'b0;
      end else if (sel == BPS_S_WR) begin
        wbuf_issued <= 1'b1;
      end
      if (opr_req && opr_we && !wbuf_valid) begin
        wbuf_valid <= 1'b1;
        wbuf_addr <= opr_addr;
        wbuf_data <= opr_wdata;
        wbuf_size <= opr_size;
      end
    end
  end
  assign wr_stall = wbuf_valid;

  // Operand read request and assembly
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rd_busy <= 1'b0;
      rd_issued <= 1'b0;
      rd_addr <= 32'h0;
      rd_size <= SZ_WORD;
      rd_hi <= 16'h0;
      rd_done <= 1'b0;
      rd_data <= 32'h0;
    end else begin
      rd_done <= rd_fin;
      if (rd_fin) begin
        rd_busy <= 1'b0;
        rd_issued <= 1'b0;
        rd_data <= cur_long ? {rd_hi, bc_rdata} : {16'h0, bc_rdata};
      end else if (sel == BPS_S_RD) begin
        rd_issued <= 1'b1;
      end
      if (bc_done && cur_kind == BPS_K_RD && cur_long && !cur_lo) begin
        rd_hi <= bc_rdata;
      end
      if (opr_req && !opr_we && !rd_busy) begin
        rd_busy <= 1'b1;
        rd_addr <= opr_addr;
        rd_size <= opr_size;
      end
    end
  end

  // ************************************************************
  // Prefetch controller and pipeline
  // ************************************************************
  // Prefetch address and flight tracking
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pf_addr <= RESET_FETCH_ADDR;
      pf_inflight <= 1'b0;
      cur_stale <= 1'b0;
    end else begin
      if (flow_change) begin
        pf_addr <= flow_addr;
      end else if (sel == BPS_S_PF) begin
        pf_addr <= pf_addr + WORD_STEP;
      end
      if (sel == BPS_S_PF) begin
        pf_inflight <= 1'b1;
      end else if (bc_done && cur_kind == BPS_K_PF) begin
        pf_inflight <= 1'b0;
      end
      if (flow_change && pf_inflight) begin
        cur_stale <= 1'b1;
      end else if (sel == BPS_S_PF) begin
        cur_stale <= 1'b0;
      end
    end
  end

  assign push = bc_done && (cur_kind == BPS_K_PF) && !cur_stale && !flow_change;
  assign pop = word_use && (pipe_cnt != 3'h0) && !flow_change;

  // Occupancy after this cycle
  always_comb begin
    next_pipe_cnt = pipe_cnt;
    if (flow_change) begin
      next_pipe_cnt = 3'h0;
    end else begin
      next_pipe_cnt = pipe_cnt + {2'h0, push} - {2'h0, pop};
    end
  end

  // Word store; a used word frees a slot for its replacement
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pipe_cnt <= 3'h0;
      instr_valid <= 1'b0;
      for (int i = 0; i < PIPE_SLOTS + PIPE_BUF; i++) begin
        pipe_mem[i] <= 16'h0;
      end
    end else begin
      pipe_cnt <= next_pipe_cnt;
      instr_valid <= (next_pipe_cnt != 3'h0);
      if (pop) begin
        for (int i = 0; i < PIPE_SLOTS + PIPE_BUF - 1; i++) begin
          pipe_mem[i] <= pipe_mem[i + 1];
        end
      end
      if (push) begin
        pipe_mem[2'(pipe_cnt - {2'h0, pop})] <= bc_rdata;
      end
    end
  end
  assign instr_word = pipe_mem[0];

  // ************************************************************
  // Sequencer timing
  // ************************************************************
  // two idle clocks to refill
  // idle equals one two-clock bus cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      hold_cnt <= 2'h0;
      seq_hold <= 1'b0;
    end else if (flow_change) begin
      hold_cnt <= HOLD_LOAD;
      seq_hold <= 1'b1;
    end else if (hold_cnt != 2'h0) begin
      hold_cnt <= hold_cnt - 2'h1;
    end else begin
      seq_hold <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      overlap_cycles <= 4'h0;
    end else begin
      overlap_cycles <= bps_min4(tail_cycles, head_cycles);
    end
  end

  // ************************************************************
  // Bus cycle engine
  // ************************************************************
  bps_bus_cycle u_cycle (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(bus_start),
    .addr(bus_addr_q),
    .size(bus_size_q),
    .we(bus_we_q),
    .wdata(bus_wdata_q),
    .ifetch(bus_if_q),
    .onchip(bus_onchip_q),
    .sync_mode(sync_mode),
    .onchip_rdata(onchip_rdata),
    .ext_ack_n(ext_ack_n),
    .ext_data_in(ext_data_in),
    .busy(bc_busy),
    .done(bc_done),
    .rdata(bc_rdata),
    .bus_as_n(bus_as_n),
    .bus_addr(bus_addr),
    .bus_size(bus_size),
    .bus_rd(bus_rd),
    .bus_data_out(bus_data_out),
    .bus_data_oe_n(bus_data_oe_n),
    .bus_ifetch(bus_ifetch)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  flush_empty_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    flow_change |=> !instr_valid) else $error("pipeline not flushed");
  pf_no_cof_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (bus_start && bus_if_q) |-> $past(!next_is_cof && !flow_change))
    else $error("prefetch despite flow change");
  wbuf_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wbuf_valid && !wr_fin && opr_req && opr_we) |=> $stable(wbuf_data))
    else $error("write buffer overwritten");
  op_first_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (idle_now && !lo_cont && wbuf_valid && !wbuf_issued) |=> (bus_start && cur_kind == BPS_K_WR))
    else $error("operand write not granted first");
  long_pair_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    lo_cont |=> (bus_start && cur_lo && bus_addr_q == $past(bus_addr_q) + WORD_STEP))
    else $error("long low word not consecutive");
  onchip_two_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (bus_start && bus_onchip_q) |-> ##2 bc_done) else $error("on-chip cycle not two clocks");
  hold_two_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (flow_change ##1 !flow_change [*2]) |-> (seq_hold ##1 !seq_hold))
    else $error("hold length wrong");
  hold_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    flow_change |=> seq_hold [*2]) else $error("hold not two clocks");
  stale_drop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (bc_done && cur_kind == BPS_K_PF && cur_stale && !pop && !flow_change)
    |=> pipe_cnt == $past(pipe_cnt)) else $error("stale prefetch loaded");
  overlap_min_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    1'b1 |=> (overlap_cycles <= $past(tail_cycles) && overlap_cycles <= $past(head_cycles)
    && (overlap_cycles == $past(tail_cycles) || overlap_cycles == $past(head_cycles))))
    else $error("overlap not the minimum");

endmodule
`default_nettype wire

// ==== sim/bps_mem_model.sv ====
/*
  Targets behind the scheduler bus: on-chip block and slow external memory.
  Assumes on-chip addresses ffff_xxxx and read data derived from the address.
*/
`timescale 1ns/1ns
`default_nettype none
module bps_mem_model #(
  parameter int WAIT = 3
) (
  input wire logic sys_clk,
  input wire logic bus_as_n,
  input wire logic [31:0] bus_addr,
  output logic [15:0] onchip_rdata,
  output logic ext_ack_n,
  output logic [15:0] ext_data_in
);
  // ************************************************************
  // Targets
  // ************************************************************
  int cnt = 0;
  logic [15:0] last = 16'h0;
  // On-chip block answers in the same clock, garbage when not selected
  assign onchip_rdata = (bus_addr[31:16] == 16'hffff) ? (bus_addr[15:0] ^ 16'h3c3c) :
    ~(bus_addr[15:0] ^ 16'h3c3c);
  initial begin
    ext_ack_n = 1'b1;
  end
  // External data follows the strobe at once, inverted once released
  assign ext_data_in = bus_as_n ? ~last : (bus_addr[15:0] ^ 16'h3c3c);
  // External target acks after WAIT clocks
  always @(posedge sys_clk) begin
    if (bus_as_n) begin
      cnt <= 0;
      ext_ack_n <= 1'b1;
    end else begin
      cnt <= cnt + 1;
      last <= bus_addr[15:0] ^ 16'h3c3c;
      if (cnt >= WAIT - 1) ext_ack_n <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb_bps_scheduler.sv ====
/*
  Self-checking bench for the bus prefetch scheduler.
  Assumes bps_mem_model on the bus side and on-chip addresses ffff_xxxx.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_bps_scheduler;
  import bps_pkg::*;
  typedef struct {logic ifetch; logic rd; logic [31:0] addr; logic [15:0] data;} bps_ent_s;
  typedef struct {logic [31:0] a; logic [1:0] sz; logic sync; logic [3:0] tl; logic [3:0] hd;
    int lat; logic [3:0] ovl;} bps_row_s;
  logic sys_clk = 1'b0, nrst = 1'b0, flow_change = 1'b0, next_is_cof = 1'b1, word_use = 1'b0;
  logic repl_early = 1'b0, opr_req = 1'b0, opr_we = 1'b0, sync_mode = 1'b0;
  logic [1:0] opr_size = SZ_WORD;
  logic [31:0] flow_addr = 32'h0, opr_addr = 32'h0, opr_wdata = 32'h0, last_addr = 32'h0;
  logic [3:0] tail_cycles = 4'h0, head_cycles = 4'h0;
  logic [15:0] onchip_rdata, ext_data_in, instr_word, bus_data_out;
  logic ext_ack_n, wr_stall, rd_busy, rd_done, seq_hold, instr_valid, bus_as_n, bus_rd;
  logic bus_data_oe_n, bus_ifetch;
  logic [31:0] rd_data, bus_addr, exp_d;
  logic [1:0] bus_size;
  logic [3:0] overlap_cycles;
  int fails = 0, checks = 0, n;
  bps_ent_s log_q[$];
  bps_row_s rows[5] = '{'{32'hffff0010, SZ_WORD, 1'b0, 4'h3, 4'h5, 4, 4'h3},
    '{32'hffff0030, SZ_LONG, 1'b0, 4'h7, 4'h2, 7, 4'h2},
    '{32'h00002000, SZ_WORD, 1'b0, 4'h0, 4'h9, 0, 4'h0},
    '{32'h00002010, SZ_LONG, 1'b1, 4'hf, 4'hf, 0, 4'hf},
    '{32'h00002020, SZ_WORD, 1'b1, 4'h4, 4'h4, 0, 4'h4}};

  always #20 sys_clk = ~sys_clk;

  bps_scheduler uut (
    .sys_clk(sys_clk), .nrst(nrst), .flow_change(flow_change), .flow_addr(flow_addr),
    .next_is_cof(next_is_cof), .word_use(word_use), .repl_early(repl_early), .opr_req(opr_req),
    .opr_we(opr_we), .opr_size(opr_size), .opr_addr(opr_addr), .opr_wdata(opr_wdata),
    .tail_cycles(tail_cycles), .head_cycles(head_cycles), .sync_mode(sync_mode),
    .onchip_rdata(onchip_rdata), .ext_ack_n(ext_ack_n), .ext_data_in(ext_data_in),
    .wr_stall(wr_stall), .rd_busy(rd_busy), .rd_done(rd_done), .rd_data(rd_data),
    .seq_hold(seq_hold), .instr_word(instr_word), .instr_valid(instr_valid),
    .overlap_cycles(overlap_cycles), .bus_as_n(bus_as_n), .bus_addr(bus_addr),
    .bus_size(bus_size), .bus_rd(bus_rd), .bus_data_out(bus_data_out),
    .bus_data_oe_n(bus_data_oe_n), .bus_ifetch(bus_ifetch));
  bps_mem_model #(.WAIT(3)) mem (.sys_clk(sys_clk), .bus_as_n(bus_as_n), .bus_addr(bus_addr),
    .onchip_rdata(onchip_rdata), .ext_ack_n(ext_ack_n), .ext_data_in(ext_data_in));

  // ************************************************************
  // Helpers
  // ************************************************************
  // Bus log: one entry for each new address on the pins
  always @(posedge sys_clk) begin
    #1;
    if (bus_addr !== last_addr) begin
      log_q.push_back('{bus_ifetch, bus_rd, bus_addr, bus_data_out});
      last_addr = bus_addr;
    end
  end
  function automatic logic [15:0] pat(input logic [31:0] a);
    return a[15:0] ^ 16'h3c3c;
  endfunction
  function automatic int pf_count();
    int c = 0;
    foreach (log_q[i]) if (log_q[i].ifetch === 1'b1 && log_q[i].addr[31:16] === 16'hffff) c++;
    return c;
  endfunction
  task automatic check(input string name, input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  // Bounded wait: 0 read done, 1 write buffer empty, 2 external prefetch on pins
  task automatic wait_hi(input int sel, output int cyc);
    cyc = 0;
    do begin
      tick(1);
      cyc++;
    end while (!((sel == 0 && rd_done === 1'b1) || (sel == 1 && wr_stall === 1'b0) ||
      (sel == 2 && bus_ifetch === 1'b1 && bus_as_n === 1'b0)) && cyc < 200);
  endtask
  // Operand read, optionally with a pipeline word used at the same edge
  task automatic do_read(input logic [31:0] a, input logic [1:0] sz, input logic wu,
      output int cyc);
    @(posedge sys_clk);
    opr_req <= 1'b1;
    opr_we <= 1'b0;
    opr_addr <= a;
    opr_size <= sz;
    word_use <= wu;
    @(posedge sys_clk);
    opr_req <= 1'b0;
    word_use <= 1'b0;
    wait_hi(0, cyc);
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      @(posedge sys_clk);
      sync_mode <= rows[i].sync;
      tail_cycles <= rows[i].tl;
      head_cycles <= rows[i].hd;
      log_q.delete();
      do_read(rows[i].a, rows[i].sz, 1'b0, n);
      exp_d = (rows[i].sz == SZ_LONG) ? {pat(rows[i].a), pat(rows[i].a + 32'h2)} :
        {16'h0, pat(rows[i].a)};
      check("rd_data", rd_data, exp_d);
      if (rows[i].lat != 0) check("rd_lat", n, rows[i].lat);
      check("rd_addr0", log_q[0].addr, rows[i].a);
      if (rows[i].sz == SZ_LONG) check("rd_addr1", log_q[1].addr, rows[i].a + 32'h2);
      else check("rd_cycles", log_q.size(), 1);
      check("overlap", overlap_cycles, rows[i].ovl);
    end
    // Long write buffered, second write refused, read queued behind
    log_q.delete();
    @(posedge sys_clk);
    opr_req <= 1'b1;
    opr_we <= 1'b1;
    opr_size <= SZ_LONG;
    opr_addr <= 32'hffff0020;
    opr_wdata <= 32'h1234abcd;
    @(posedge sys_clk);
    opr_addr <= 32'hffff0060;
    opr_wdata <= 32'h55aa55aa;
    #1;
    check("wr_stall", wr_stall, 1'b1);
    do_read(32'hffff0040, SZ_WORD, 1'b0, n);
    check("rd_after_wr", rd_data, {16'h0, pat(32'hffff0040)});
    check("wr_count", log_q.size(), 3);
    check("wr_hi", {log_q[0].addr[15:0], log_q[0].data}, 32'h00201234);
    check("wr_lo", {log_q[1].addr[15:0], log_q[1].data}, 32'h0022abcd);
    check("wr_then_rd", {log_q[0].rd, log_q[2].addr}, 33'h0ffff0040);
    wait_hi(1, n);
    check("wr_free", wr_stall, 1'b0);
    // Flush during an external prefetch, refill from on-chip path
    @(posedge sys_clk);
    flow_change <= 1'b1;
    flow_addr <= 32'h00001000;
    next_is_cof <= 1'b0;
    @(posedge sys_clk);
    flow_change <= 1'b0;
    wait_hi(2, n);
    log_q.delete();
    @(posedge sys_clk);
    flow_change <= 1'b1;
    flow_addr <= 32'hffff0100;
    @(posedge sys_clk);
    flow_change <= 1'b0;
    #1;
    check("hold1", seq_hold, 1'b1);
    tick(1);
    check("hold2", seq_hold, 1'b1);
    tick(1);
    check("hold3", seq_hold, 1'b0);
    tick(40);
    check("refill", {instr_valid, instr_word}, {1'b1, pat(32'hffff0100)});
    check("pf_full", pf_count(), 3);
    @(posedge sys_clk);
    word_use <= 1'b1;
    @(posedge sys_clk);
    word_use <= 1'b0;
    tick(20);
    check("pf_repl", pf_count(), 4);
    check("pop", instr_word, pat(32'hffff0102));
    @(posedge sys_clk);
    next_is_cof <= 1'b1;
    word_use <= 1'b1;
    @(posedge sys_clk);
    word_use <= 1'b0;
    tick(20);
    check("pf_cof", pf_count(), 4);
    // Early replacement allows the buffer word
    @(posedge sys_clk);
    next_is_cof <= 1'b0;
    repl_early <= 1'b1;
    tick(20);
    check("pf_early", pf_count(), 6);
    // Operand wins against a prefetch freed at the same edge
    log_q.delete();
    do_read(32'hffff0200, SZ_WORD, 1'b1, n);
    tick(2);
    check("prio_opr", {log_q[0].ifetch, log_q[0].addr}, 33'h0ffff0200);
    check("prio_pf", {log_q[1].ifetch, log_q[1].addr}, 33'h1ffff010c);
    // Second reset in mid-run
    @(posedge sys_clk);
    flow_change <= 1'b1;
    @(posedge sys_clk);
    flow_change <= 1'b0;
    nrst <= 1'b0;
    tick(6);
    check("rst_pins", {bus_as_n, bus_rd, bus_data_oe_n, bus_size, bus_ifetch}, 6'h3a);
    check("rst_state", {wr_stall, rd_busy, rd_done, seq_hold, instr_valid}, 5'h0);
    stop_test();
  end
  // Watchdog cuts a hung run short
  initial begin
    #200000;
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
